// ===== logic/irrc_pkg.sv
/*
  Shared constants for the infrared remote command receiver: reference
  tick timing, word layout, command codes, modes and register map.
  Assumes a 100 MHz system clock and a 480 kHz reference tick.
*/
package irrc_pkg;
  // ----------------------------------------------------------------
  // reference timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int REF_KHZ = 480;
  localparam int REF_DIV = CLK_KHZ / REF_KHZ;
  localparam int GLITCH_US    = 100;
  localparam int MIN_SPACE_US = 400;
  localparam int BIT_SPLIT_US = 1500;
  localparam int WORD_END_US  = 3200;
  localparam int CMD_END_US   = 60000;
  localparam int REPEAT_US    = 102000;
  localparam int FLASH_DHZ    = 49;     // 4.9 Hz in tenths
  localparam int GLITCH_TICKS    = (GLITCH_US * REF_KHZ + 999) / 1000;
  localparam int MIN_SPACE_TICKS = (MIN_SPACE_US * REF_KHZ + 999) / 1000;
  localparam int BIT_SPLIT_TICKS = (BIT_SPLIT_US * REF_KHZ + 999) / 1000;
  localparam int WORD_END_TICKS  = (WORD_END_US * REF_KHZ + 999) / 1000;
  localparam int CMD_END_TICKS   = (CMD_END_US * REF_KHZ) / 1000;
  localparam int REPEAT_TICKS    = (REPEAT_US * REF_KHZ) / 1000;
  localparam int FLASH_HALF_TICKS = (REF_KHZ * 10000) / (2 * FLASH_DHZ);
  // ----------------------------------------------------------------
  // word layout, modes and commands
  // ----------------------------------------------------------------
  localparam int WORD_BITS   = 10;
  localparam int WORD_PULSES = 11;
  localparam logic [2:0] KEY_OK = 3'h5;
  localparam logic [1:0] MATCH_DONE = 2'h3;
  typedef enum logic [1:0] {
    MODE_TV = 2'b00, MODE_RSV = 2'b01, MODE_TEXT = 2'b10, MODE_VIEW = 2'b11
  } irrc_mode_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00, ACT_SINGLE = 2'b01, ACT_REPEAT = 2'b10
  } irrc_act_t;
  localparam logic [6:0] CODE_NORM = 7'h00;
  localparam logic [6:0] CODE_TV   = 7'h03;
  localparam logic [6:0] CODE_RSV  = 7'h04;
  localparam logic [6:0] CODE_VIEW = 7'h1D;
  localparam logic [6:0] CODE_MIX  = 7'h1E;
  localparam logic [6:0] CODE_TEXT = 7'h1F;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_DATA = 8'h08;
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam int DATA_NEW_BIT = 16;
endpackage

// ===== logic/irrc_demod.sv
/*
  Pulse-spacing demodulator: filters glitches on the active-low serial
  input, measures spacing between pulses and assembles 10-bit words.
  Assumes si_n_i synchronous to clk_i and tick_i one cycle per ref tick.
*/
`timescale 1ns/100ps
module irrc_demod
  import irrc_pkg::*;
#(
  parameter int WORD_END_T = WORD_END_TICKS
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 tick_i,
  input  wire logic                 enable_i,
  input  wire logic                 si_n_i,
  output logic [WORD_BITS-1:0]      word_o,
  output logic                      word_valid_o,
  output logic                      word_end_o
);
  logic [5:0]            low_cnt;
  logic                  pulse_seen;
  logic                  pulse_ev;
  logic [11:0]           sp_cnt;
  logic [3:0]            npulse;
  logic [WORD_BITS-1:0]  shreg;
  logic                  bad;

  // ----------------------------------------------------------------
  // glitch filter
  // ----------------------------------------------------------------
  // a low level counts as a pulse only once it has lasted the minimum
  assign pulse_ev = tick_i && !si_n_i && !pulse_seen &&
                    (low_cnt == 6'(GLITCH_TICKS - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i || si_n_i) begin
      low_cnt    <= 6'h00;
      pulse_seen <= 1'b0;
    end else if (tick_i && !pulse_seen) begin
      low_cnt    <= low_cnt + 6'h01;
      pulse_seen <= pulse_ev;
    end
  end

  // ----------------------------------------------------------------
  // spacing measurement and word assembly
  // ----------------------------------------------------------------
  // spacing counted in ref ticks, so thresholds track the oscillator
  always_ff @(posedge clk_i) begin
    word_valid_o <= 1'b0;
    word_end_o   <= 1'b0;
    if (rst_i || !enable_i) begin
      sp_cnt <= 12'h000;
      npulse <= 4'h0;
      shreg  <= '0;
      bad    <= 1'b0;
      word_o <= '0;
    end else if (pulse_ev) begin
      sp_cnt <= 12'h000;
      if (npulse != 4'hF) npulse <= npulse + 4'h1;
      if (npulse != 4'h0) begin
        if (sp_cnt < 12'(MIN_SPACE_TICKS)) bad <= 1'b1;
        // short spacing is 0, long spacing is 1, first bit lands lowest
        shreg <= {(sp_cnt >= 12'(BIT_SPLIT_TICKS)),
                  shreg[WORD_BITS-1:1]};
      end
    end else if (tick_i && npulse != 4'h0) begin
      if (sp_cnt == 12'(WORD_END_T - 1)) begin
        word_end_o   <= 1'b1;
        word_o       <= shreg;
        word_valid_o <= (npulse == 4'(WORD_PULSES)) && !bad;
        sp_cnt <= 12'h000;
        npulse <= 4'h0;
        bad    <= 1'b0;
      end else begin
        sp_cnt <= sp_cnt + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_short_space;
    @(posedge clk_i) disable iff (rst_i)
    pulse_ev && npulse != 4'h0 && sp_cnt < 12'(MIN_SPACE_TICKS)
      |=> !word_valid_o until_with word_end_o;
  endproperty
  a_short_space: assert property (p_short_space)
    else $error("short spacing word accepted");

  property p_valid_end;
    @(posedge clk_i) disable iff (rst_i)
    word_valid_o |-> word_end_o && $past(npulse) == 4'(WORD_PULSES);
  endproperty
  a_valid_end: assert property (p_valid_end)
    else $error("valid word without end of word");
endmodule // irrc_demod

// ===== logic/irrc_flash.sv
/*
  Reception indicator flasher: drives a square wave of about 4.9 Hz
  while active, and releases the pin (high impedance) otherwise.
  Assumes tick_i one cycle per ref tick; oe_n low means driving.
*/
`timescale 1ns/100ps
module irrc_flash
  import irrc_pkg::*;
#(
  parameter int HALF_T = FLASH_HALF_TICKS
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic active_i,
  output logic      ind_o,
  output logic      ind_oe_n_o
);
  logic [16:0] cnt;

  // ----------------------------------------------------------------
  // half-period toggler
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !active_i) begin
      cnt        <= 17'h00000;
      ind_o      <= 1'b0;
      ind_oe_n_o <= 1'b1;
    end else begin
      ind_oe_n_o <= 1'b0;
      if (tick_i) begin
        if (cnt == 17'(HALF_T - 1)) begin
          cnt   <= 17'h00000;
          ind_o <= !ind_o;
        end else begin
          cnt <= cnt + 17'h00001;
        end
      end
    end
  end

  property p_hiz_idle;
    @(posedge clk_i) disable iff (rst_i)
    !active_i |=> ind_oe_n_o && !ind_o;
  endproperty
  a_hiz_idle: assert property (p_hiz_idle)
    else $error("indicator driven while idle");

  property p_half_period;
    @(posedge clk_i) disable iff (rst_i)
    active_i && $past(active_i) && !$past(rst_i) && ind_o != $past(ind_o)
      |-> $past(cnt) == 17'(HALF_T - 1);
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("indicator toggled off half period");
endmodule // irrc_flash

// ===== logic/irrc_top.sv
/*
  Infrared remote command receiver: ref tick divider, triple-match
  validation, mode tracking, command table, data output, indicator and
  a classic Wishbone register slave.
  Assumes a 100 MHz clock, synchronous active-high reset and a
  photodetector amplifier driving si_n_i low for each pulse.
*/
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/100ps
module irrc_top
  import irrc_pkg::*;
#(
  parameter int REF_DIV_P    = REF_DIV,
  parameter int WORD_END_P   = WORD_END_TICKS,
  parameter int CMD_END_P    = CMD_END_TICKS,
  parameter int REPEAT_P     = REPEAT_TICKS,
  parameter int FLASH_HALF_P = FLASH_HALF_TICKS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        si_n_i,
  output logic             mode_bit_high_o,
  output logic             mode_bit_low_o,
  output logic      [8:0]  data_o,
  output logic             data_valid_o,
  output logic             reception_indicator_o,
  output logic             reception_indicator_oe_n_o
);
  logic [7:0]           div_cnt;
  logic                 ref_tick;
  logic                 ctrl_en;
  logic [WORD_BITS-1:0] word;
  logic                 word_valid;
  logic                 word_end;
  logic [6:0]           code;
  logic                 rx_ok;
  logic [6:0]           stored;
  logic [1:0]           mcount;
  logic                 confirmed;
  logic                 execute;
  logic [16:0]          cmd_cnt;
  logic                 cmd_end;
  irrc_mode_t           mode;
  irrc_mode_t           next_mode;
  irrc_act_t            act;
  logic                 rep_on;
  logic [16:0]          rep_cnt;
  logic                 rep_fire;
  logic                 data_new;
  logic                 wb_req;

  // ----------------------------------------------------------------
  // command table
  // ----------------------------------------------------------------
  // output class of a code in a mode; unknown codes do nothing
  function automatic irrc_act_t act_of(input irrc_mode_t m,
                                       input logic [6:0] c);
    logic tv;
    logic pg;
    tv = (m == MODE_TV);
    pg = (m == MODE_TEXT) || (m == MODE_VIEW);
    act_of = ACT_NONE;
    case (c) inside
      7'h00:           act_of = (m == MODE_RSV) ? ACT_NONE : ACT_SINGLE;
      [7'h01:7'h04]:   act_of = ACT_SINGLE;
      7'h05:           act_of = tv ? ACT_NONE : ACT_SINGLE;
      7'h06:           act_of = pg ? ACT_REPEAT
                                   : (tv ? ACT_NONE : ACT_SINGLE);
      7'h07:           act_of = pg ? ACT_REPEAT : ACT_SINGLE;
      [7'h0C:7'h0F]:   act_of = pg ? ACT_SINGLE : ACT_NONE;
      [7'h1A:7'h1C],
      [7'h30:7'h39]:   act_of = tv ? ACT_NONE : ACT_SINGLE;
      [7'h1D:7'h1F]:   act_of = ACT_SINGLE;
      default:         act_of = ACT_NONE;
    endcase
  endfunction

  // mode after a code; norm and mix are held off in reserved mode
  function automatic irrc_mode_t mode_of(input irrc_mode_t m,
                                         input logic [6:0] c);
    mode_of = m;
    case (c)
      CODE_NORM: mode_of = (m == MODE_RSV) ? m : MODE_TV;
      CODE_TV:   mode_of = MODE_TV;
      CODE_RSV:  mode_of = MODE_RSV;
      CODE_VIEW: mode_of = MODE_VIEW;
      CODE_MIX:  mode_of = (m == MODE_RSV) ? m : MODE_TEXT;
      CODE_TEXT: mode_of = MODE_TEXT;
      default:   mode_of = m;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // reference tick divider
  // ----------------------------------------------------------------
  // 100 MHz / 208 sits a little fast of 480 kHz; thresholds scale
  assign ref_tick = (div_cnt == 8'(REF_DIV_P - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || ref_tick) div_cnt <= 8'h00;
    else                   div_cnt <= div_cnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // demodulator and indicator
  // ----------------------------------------------------------------
  irrc_demod #(
    .WORD_END_T (WORD_END_P)
  ) u_demod (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (ref_tick),
    .enable_i     (ctrl_en),
    .si_n_i       (si_n_i),
    .word_o       (word),
    .word_valid_o (word_valid),
    .word_end_o   (word_end)
  );

  irrc_flash #(
    .HALF_T (FLASH_HALF_P)
  ) u_flash (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .tick_i     (ref_tick),
    .active_i   (confirmed),
    .ind_o      (reception_indicator_o),
    .ind_oe_n_o (reception_indicator_oe_n_o)
  );

  // ----------------------------------------------------------------
  // triple-match validation
  // ----------------------------------------------------------------
  assign code      = word[6:0];
  assign rx_ok     = word_valid && (word[9:7] == KEY_OK);
  assign confirmed = (mcount == MATCH_DONE);
  assign execute   = rx_ok && (code == stored) &&
                     (mcount == MATCH_DONE - 2'h1);
  assign cmd_end   = ref_tick && (mcount != 2'h0) &&
                     (cmd_cnt == 17'(CMD_END_P - 1));

  // a lone corrupted word only restarts the count, never executes
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_en) begin
      stored <= 7'h00;
      mcount <= 2'h0;
    end else if (rx_ok) begin
      if (mcount != 2'h0 && code == stored) begin
        if (!confirmed) mcount <= mcount + 2'h1;
      end else begin
        stored <= code;
        mcount <= 2'h1;
      end
    end else if (cmd_end) begin
      mcount <= 2'h0;
    end
  end

  // command-end timer restarts at every word end
  always_ff @(posedge clk_i) begin
    if (rst_i || word_end || mcount == 2'h0) begin
      cmd_cnt <= 17'h00000;
    end else if (ref_tick) begin
      cmd_cnt <= cmd_cnt + 17'h00001;
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  assign act       = act_of(mode, code);
  assign next_mode = mode_of(mode, code);

  always_ff @(posedge clk_i) begin
    if (rst_i) mode <= MODE_TV;
    else if (execute) mode <= next_mode;
  end

  assign mode_bit_high_o = mode[1];
  assign mode_bit_low_o  = mode[0];

  // ----------------------------------------------------------------
  // data output and repetition
  // ----------------------------------------------------------------
  assign rep_fire = rep_on && confirmed && ref_tick &&
                    (rep_cnt == 17'(REPEAT_P - 1));

  // execute lands while the count still reads two, so it must not be masked
  always_ff @(posedge clk_i) begin
    if (rst_i || (!confirmed && !execute)) begin
      rep_on  <= 1'b0;
      rep_cnt <= 17'h00000;
    end else if (execute) begin
      rep_on  <= (act == ACT_REPEAT);
      rep_cnt <= 17'h00000;
    end else if (ref_tick) begin
      rep_cnt <= rep_fire ? 17'h00000 : rep_cnt + 17'h00001;
    end
  end

  // emission carries the mode bits in force after the command
  always_ff @(posedge clk_i) begin
    data_valid_o <= 1'b0;
    if (rst_i) begin
      data_o <= 9'h000;
    end else if (execute && act != ACT_NONE) begin
      data_o       <= {next_mode, code};
      data_valid_o <= 1'b1;
    end else if (rep_fire) begin
      data_o       <= {mode, stored};
      data_valid_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // wishbone register slave
  // ----------------------------------------------------------------
  // one wait state; unmapped reads return zero, writes are dropped
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else       wb_ack_o <= wb_req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en <= CTRL_EN_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == ADR_CTRL) begin
      ctrl_en <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: wb_dat_o <= {31'h00000000, ctrl_en};
        ADR_STAT: wb_dat_o <= {27'h0000000, confirmed, mcount, mode};
        ADR_DATA: wb_dat_o <= {15'h0000, data_new, 7'h00, data_o};
        default:  wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // new-data flag: an emission in the reading cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) data_new <= 1'b0;
    else if (data_valid_o) data_new <= 1'b1;
    else if (wb_req && !wb_we_i && wb_adr_i == ADR_DATA)
      data_new <= 1'b0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_emit_confirmed;
    @(posedge clk_i) disable iff (rst_i)
    data_valid_o |-> confirmed;
  endproperty
  a_emit_confirmed: assert property (p_emit_confirmed)
    else $error("data emitted before third match");

  property p_exec_third;
    @(posedge clk_i) disable iff (rst_i)
    rx_ok && code == stored && mcount == 2'h2 |=> mcount == 2'h3;
  endproperty
  a_exec_third: assert property (p_exec_third)
    else $error("third identical word not confirmed");

  property p_key_filter;
    @(posedge clk_i) disable iff (rst_i)
    word_valid && word[9:7] != KEY_OK && !cmd_end && ctrl_en
      |=> $stable(mcount) && $stable(stored);
  endproperty
  a_key_filter: assert property (p_key_filter)
    else $error("word with wrong key code counted");

  property p_norm_tv;
    @(posedge clk_i) disable iff (rst_i)
    execute && code == CODE_NORM && mode != MODE_RSV |=> mode == MODE_TV;
  endproperty
  a_norm_tv: assert property (p_norm_tv)
    else $error("norm did not return to tv");

  property p_mix_rsv;
    @(posedge clk_i) disable iff (rst_i)
    execute && code == CODE_MIX && mode == MODE_RSV |=> mode == MODE_RSV;
  endproperty
  a_mix_rsv: assert property (p_mix_rsv)
    else $error("mix changed reserved mode");

  property p_no_output;
    @(posedge clk_i) disable iff (rst_i)
    execute && act == ACT_NONE |=> !data_valid_o;
  endproperty
  a_no_output: assert property (p_no_output)
    else $error("no-output command emitted data");

  property p_single;
    @(posedge clk_i) disable iff (rst_i)
    execute && act == ACT_SINGLE |=> data_valid_o ##1 !data_valid_o[*8];
  endproperty
  a_single: assert property (p_single)
    else $error("single-word command not emitted once");

  property p_mode_bits;
    @(posedge clk_i) disable iff (rst_i)
    data_valid_o |-> data_o[8:7] == {mode_bit_high_o, mode_bit_low_o};
  endproperty
  a_mode_bits: assert property (p_mode_bits)
    else $error("data word mode bits differ from pins");

  property p_repeat;
    @(posedge clk_i) disable iff (rst_i)
    rep_fire |=> data_valid_o && data_o[6:0] == $past(stored);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat period passed without emission");

  property p_cmd_end;
    @(posedge clk_i) disable iff (rst_i)
    cmd_end && !rx_ok |=> mcount == 2'h0 ##1 reception_indicator_oe_n_o;
  endproperty
  a_cmd_end: assert property (p_cmd_end)
    else $error("command end did not clear match");

  c_execute: cover property (@(posedge clk_i) disable iff (rst_i)
    execute && act == ACT_SINGLE);
  c_repeat: cover property (@(posedge clk_i) disable iff (rst_i)
    rep_fire);
  c_cmd_end: cover property (@(posedge clk_i) disable iff (rst_i)
    cmd_end && confirmed);
endmodule // irrc_top

// ===== verif/irrc_ir_tx.sv
/*
  Remote transmitter model: pulse-spacing words on the ir line.
  Assumes the receiver ref tick is TICK clocks long; line idles high.
*/
`timescale 1ns/100ps
module irrc_ir_tx #(
  parameter int TICK = 2
) (
  input  wire logic clk_i,
  output logic      si_n_o
);
  initial si_n_o = 1'b1;
  // hold one level for a number of ref ticks
  task automatic hold(input logic lvl, input int ticks);
    si_n_o <= lvl;
    repeat (ticks * TICK) @(posedge clk_i);
  endtask
  // eleven 0.5 ms pulses carry ten bits, lsb first
  task automatic send_word(input logic [9:0] w, input logic glitch);
    int sp;
    @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      hold(1'b0, 240);
      if (i == 10) break;
      sp = w[i] ? 960 : 480;
      // a 20-tick dip mid-gap must not count as a pulse
      if (glitch && i == 4) begin
        hold(1'b1, 100);
        hold(1'b0, 20);
        hold(1'b1, sp - 360);
      end else begin
        hold(1'b1, sp - 240);
      end
    end
    hold(1'b1, 1700); // idle gap ends the word
  endtask
endmodule // irrc_ir_tx

// ===== verif/testbench.sv
/*
  Bench for irrc_top: wishbone tasks and ir word scenarios.
  Assumes irrc_ir_tx on si_n_i and shortened divider, command-end timeout and flash half period.
*/
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] wdo, rd;
  logic        ack, mh, ml, dv, ind, ind_oe_n, si_n, v;
  logic [8:0]  dout, last;
  int          n_mismatch = 0, num_checks = 0, n_valid = 0;

  always #5 clk_i = ~clk_i;

  irrc_top #(.REF_DIV_P(2), .CMD_END_P(9000), .FLASH_HALF_P(50))
  irrc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wdo), .wb_ack_o(ack), .si_n_i(si_n),
    .mode_bit_high_o(mh), .mode_bit_low_o(ml), .data_o(dout),
    .data_valid_o(dv), .reception_indicator_o(ind),
    .reception_indicator_oe_n_o(ind_oe_n));
  irrc_ir_tx #(.TICK(2)) irrc_ir_tx_inst (.clk_i(clk_i), .si_n_o(si_n));

  // count emissions; data_valid is a one-cycle pulse
  always @(posedge clk_i) begin
    if (dv === 1'b1) begin
      n_valid++;
      last = dout;
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // classic single cycle, held until ack is sampled
  task automatic wb(logic w, logic [7:0] a, logic [3:0] s,
                    logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    if (n >= 20) give_verdict;
    q = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // idle status, unmapped write dropped, enable bit honours sel
  task automatic t_regs;
    wb(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF, rd);
    wb(1'b0, 8'h0C, 4'hF, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    wb(1'b0, 8'h04, 4'hF, 32'h0, rd);
    chk("stat_idle", rd, 32'h0);
    wb(1'b1, 8'h00, 4'hE, 32'h0, rd);
    wb(1'b0, 8'h00, 4'hF, 32'h0, rd);
    chk("ctrl_sel", rd, 32'h1);
    wb(1'b1, 8'h00, 4'hF, 32'h0, rd);
    wb(1'b0, 8'h00, 4'hF, 32'h0, rd);
    chk("ctrl_off", rd, 32'h0);
    wb(1'b1, 8'h00, 4'hF, 32'h1, rd);
  endtask

  // bad key ignored, glitches ignored, third match executes
  task automatic t_triple;
    irrc_ir_tx_inst.send_word(10'h204, 1'b0);
    irrc_ir_tx_inst.send_word(10'h284, 1'b1);
    irrc_ir_tx_inst.send_word(10'h284, 1'b1);
    chk("early", n_valid, 0);
    irrc_ir_tx_inst.send_word(10'h284, 1'b0);
    chk("count", n_valid, 1);
    chk("data", last, 32'h084);
    chk("mode", {mh, ml}, 32'h1);
    wb(1'b0, 8'h04, 4'hF, 32'h0, rd);
    chk("stat", rd, 32'h1D);
    wb(1'b0, 8'h08, 4'hF, 32'h0, rd);
    chk("data_new", rd, 32'h10084);
    wb(1'b0, 8'h08, 4'hF, 32'h0, rd);
    chk("data_old", rd, 32'h84);
  endtask

  // flashing while confirmed, float after command end
  task automatic t_flash;
    int n;
    chk("drive", ind_oe_n, 0);
    v = ind;
    repeat (100) @(posedge clk_i);
    chk("blink", ind, !v);
    n = 0;
    while (ind_oe_n !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    chk("float", ind_oe_n, 1);
    wb(1'b0, 8'h04, 4'hF, 32'h0, rd);
    chk("stat_end", rd, 32'h1);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_triple;
    t_flash;
    give_verdict;
  end

  initial begin
    #1_000_000;
    n_mismatch++;
    give_verdict;
  end
endmodule // testbench
